// *** fsc_pkg.sv ***
// package for the flash security control block: offsets, field positions, codes
// assumes an 8-bit core special function register port and external-data bus
package fsc_pkg;
    // register addresses
    localparam logic [7:0]  FSC_FLASH_CONTROL_ADDR = 8'hb2;
    localparam logic [15:0] FSC_BURN_PULSE_ADDR    = 16'hffd1;
    localparam logic [15:0] FSC_SETUP_KEY_ADDR     = 16'hffd2;
    localparam logic [15:0] FSC_SEC_STATUS_ADDR    = 16'hffd7;
    localparam logic [15:0] FSC_XSFR_BASE          = 16'hfc00;
    // flash control fields
    localparam int FSC_PWE_BIT    = 0;
    localparam int FSC_MEEN_BIT   = 1;
    localparam int FSC_SECURE_BIT = 6;
    // security register fields
    localparam int FSC_PERM_BIT   = 7;
    localparam int FSC_PIN_BIT    = 5;
    localparam int FSC_FUSE1_BIT  = 1;
    localparam int FSC_FUSE0_BIT  = 0;
    // codes
    localparam logic [7:0] FSC_BURN_CODE  = 8'ha6;
    localparam logic [7:0] FSC_SETUP_CODE = 8'h54;
    // reset values
    localparam logic [7:0] FSC_REG_RESET  = 8'h00;

    // one processor access, carried as a group
    typedef struct packed {
        logic        sfr_wr;     // direct-space write strobe
        logic        sfr_rd;     // direct-space read strobe
        logic [7:0]  sfr_addr;   // direct-space address
        logic        xd_wr;      // external-data write (pointer store)
        logic        xd_rd;      // external-data read
        logic [15:0] xd_addr;    // external-data address
        logic [7:0]  wdata;      // write data
    } fsc_cpu_req_t;

    // flash port commands seen by the memory macro
    typedef struct packed {
        logic        wr;         // byte program pulse
        logic [15:0] addr;       // program address
        logic [7:0]  data;       // program byte
    } fsc_flash_wr_t;
endpackage

// *** fsc_top.sv ***
// flash security control: program-write gate, mass erase, code protect, fuse burn control
// assumes core strobes are one-cycle pulses synchronous to clk; fuse levels come from the macro
module fsc_top #(
    parameter int PAGE_BITS = 9  // byte address bits within one flash page
) (
    input  wire logic                  clk,               // core clock, 40 MHz
    input  wire logic                  sys_rst,           // synchronous reset, active high
    input  wire fsc_pkg::fsc_cpu_req_t cpu_req,           // processor access group
    input  wire logic                  irq_enabled,       // processor global interrupt enable
    input  wire logic                  debug_read_req,    // debug interface read attempt
    input  wire logic                  debug_page0_wr,    // debug interface page-zero write
    input  wire logic                  sec_request_pin,   // security-request pin level
    input  wire logic                  fuse0_blown,       // code-protect fuse state
    input  wire logic                  fuse1_blown,       // debug-disable fuse state
    output logic [7:0]                 rdata,             // register read data
    output logic                       rdata_valid,       // read data valid pulse
    output fsc_pkg::fsc_flash_wr_t     flash_wr,          // flash byte program port
    output logic                       xram_wr,           // store goes to data RAM
    output logic                       mass_erase_armed,  // mass erase permitted until a write or reset clears the enable bit
    output logic                       code_protect,      // code-protect flag
    output logic                       ext_read_block,    // deny external reads
    output logic                       burn_active,       // fuse burn in progress
    output logic [1:0]                 burn_select,       // fuse chosen: bit0 mode0, bit1 mode1
    output logic                       perm_program,      // permanent programming enabled
    output logic                       debug_disable      // debug interface off for good
);
    import fsc_pkg::*;

    logic       pwe_q, pwe_d, meen_q, meen_d, secure_q, secure_d;
    logic       armed_q, armed_d, perm_q, perm_d, burn_q, burn_d;
    logic [1:0] sel_q, sel_d;
    logic       pin_s1_q, pin_s2_q;
    logic       dbg_off_q, dbg_off_d;
    logic       ctl_wr, pulse_wr, key_wr, sec_wr, page0, flash_store;
    logic [7:0] rdata_d;
    logic       rvalid_d;
    fsc_flash_wr_t fw_d;
    logic       xram_d, block_d;

    // address decode; extra registers live only in the top external-data area
    always_comb begin
        ctl_wr   = cpu_req.sfr_wr && cpu_req.sfr_addr == FSC_FLASH_CONTROL_ADDR;
        pulse_wr = cpu_req.xd_wr && cpu_req.xd_addr >= FSC_XSFR_BASE
                   && cpu_req.xd_addr == FSC_BURN_PULSE_ADDR;
        key_wr   = cpu_req.xd_wr && cpu_req.xd_addr == FSC_SETUP_KEY_ADDR;
        sec_wr   = cpu_req.xd_wr && cpu_req.xd_addr == FSC_SEC_STATUS_ADDR;
        page0    = cpu_req.xd_addr[15:PAGE_BITS] == '0;
        // stores into register space never reach flash or RAM
        flash_store = cpu_req.xd_wr && pwe_q && cpu_req.xd_addr < FSC_XSFR_BASE;
    end

    // flash control flags
    always_comb begin
        pwe_d    = pwe_q;
        meen_d   = meen_q;
        secure_d = secure_q;
        if (flash_store) begin
            pwe_d = 1'b0;
        end
        if (ctl_wr) begin
            if (!irq_enabled) begin
                pwe_d = cpu_req.wdata[FSC_PWE_BIT];
            end
            meen_d = cpu_req.wdata[FSC_MEEN_BIT];
            if (cpu_req.wdata[FSC_SECURE_BIT]) begin
                secure_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwe_q    <= 1'b0;
            meen_q   <= 1'b0;
            secure_q <= 1'b0;
        end else begin
            pwe_q    <= pwe_d;
            meen_q   <= meen_d;
            secure_q <= secure_d;
        end
    end

    // fuse burn control; burn only runs once the setup code armed it
    always_comb begin
        armed_d = armed_q;
        perm_d  = perm_q;
        burn_d  = burn_q;
        sel_d   = sel_q;
        if (key_wr) begin
            armed_d = cpu_req.wdata == FSC_SETUP_CODE;
        end
        if (sec_wr) begin
            perm_d = cpu_req.wdata[FSC_PERM_BIT];
            sel_d  = {cpu_req.wdata[FSC_FUSE1_BIT], cpu_req.wdata[FSC_FUSE0_BIT]};
        end
        if (pulse_wr) begin
            // only one mode at a time may burn; both selected counts as none
            burn_d = cpu_req.wdata == FSC_BURN_CODE && armed_q && perm_q
                     && ^sel_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
            perm_q  <= 1'b0;
            burn_q  <= 1'b0;
            sel_q   <= 2'h0;
        end else begin
            armed_q <= armed_d;
            perm_q  <= perm_d;
            burn_q  <= burn_d;
            sel_q   <= sel_d;
        end
    end

    // request pin synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        pin_s1_q <= sec_request_pin;
        pin_s2_q <= pin_s1_q;
    end

    // debug-disable fuse sampled while reset is held, then frozen
    always_comb begin
        dbg_off_d = dbg_off_q;
        if (sys_rst) begin
            dbg_off_d = fuse1_blown;
        end
    end

    always_ff @(posedge clk) begin
        dbg_off_q <= dbg_off_d;
    end

    // read mux; unimplemented addresses answer zero (undefined to software)
    always_comb begin
        rdata_d  = 8'h00;
        rvalid_d = cpu_req.sfr_rd || (cpu_req.xd_rd && cpu_req.xd_addr >= FSC_XSFR_BASE);
        if (cpu_req.sfr_rd && cpu_req.sfr_addr == FSC_FLASH_CONTROL_ADDR) begin
            rdata_d[FSC_PWE_BIT]    = pwe_q;
            rdata_d[FSC_SECURE_BIT] = secure_q;
        end else if (cpu_req.xd_rd && cpu_req.xd_addr == FSC_SEC_STATUS_ADDR) begin
            rdata_d[FSC_PIN_BIT]   = pin_s2_q;
            rdata_d[FSC_FUSE1_BIT] = fuse1_blown;
            rdata_d[FSC_FUSE0_BIT] = fuse0_blown;
        end
    end

    // flash/RAM steering and protection outputs
    always_comb begin
        fw_d.wr   = flash_store && !(secure_q && page0);
        fw_d.addr = cpu_req.xd_addr;
        fw_d.data = cpu_req.wdata;
        xram_d    = cpu_req.xd_wr && !pwe_q && cpu_req.xd_addr < FSC_XSFR_BASE;
        block_d   = secure_q && (debug_read_req || debug_page0_wr);
    end

    // all outputs registered; flash write lands one cycle after the store
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata            <= FSC_REG_RESET;
            rdata_valid      <= 1'b0;
            flash_wr         <= '0;
            xram_wr          <= 1'b0;
            mass_erase_armed <= 1'b0;
            code_protect     <= 1'b0;
            ext_read_block   <= 1'b0;
            burn_active      <= 1'b0;
            burn_select      <= 2'h0;
            perm_program     <= 1'b0;
            debug_disable    <= 1'b0;
        end else begin
            rdata            <= rdata_d;
            rdata_valid      <= rvalid_d;
            flash_wr         <= fw_d;
            xram_wr          <= xram_d;
            mass_erase_armed <= meen_q;
            code_protect     <= secure_q;
            ext_read_block   <= block_d;
            burn_active      <= burn_q;
            burn_select      <= sel_q;
            perm_program     <= perm_q;
            debug_disable    <= dbg_off_q;
        end
    end

    // register-side checks; the flash array and erase engine sit outside this block
    // a pwe write with interrupts off wins over the self-clear, so that cycle is excluded
    a_pwe_self_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (flash_store && !(ctl_wr && !irq_enabled)) |=> !pwe_q)
        else $error("pwe not cleared after flash write");

    // interrupts on: a control write leaves pwe untouched
    a_pwe_irq_guard: assert property (@(posedge clk) disable iff (sys_rst)
        (ctl_wr && irq_enabled && !flash_store) |=> $stable(pwe_q))
        else $error("pwe changed with interrupts on");

    // interrupts off: the written bit is in pwe one cycle later
    a_pwe_set: assert property (@(posedge clk) disable iff (sys_rst)
        (ctl_wr && !irq_enabled) |=> pwe_q == $past(cpu_req.wdata[FSC_PWE_BIT]))
        else $error("pwe did not take the written value");

    // mass-erase enable shows the last written bit two cycles after the write
    a_meen_follow: assert property (@(posedge clk) disable iff (sys_rst)
        ctl_wr |=> ##1 mass_erase_armed == $past(cpu_req.wdata[FSC_MEEN_BIT], 2))
        else $error("mass erase enable does not follow the write");

    // writing a one sets the protect flag
    a_secure_set: assert property (@(posedge clk) disable iff (sys_rst)
        (ctl_wr && cpu_req.wdata[FSC_SECURE_BIT]) |=> secure_q)
        else $error("code protect not set");

    // only chip reset may drop the protect flag
    a_secure_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        secure_q |=> secure_q)
        else $error("code protect cleared");

    // protected page zero never sees a program pulse
    a_page0_block: assert property (@(posedge clk) disable iff (sys_rst)
        (flash_store && secure_q && page0) |=> !flash_wr.wr)
        else $error("page zero written under protection");

    // an allowed store, then the program pulse carrying its address and byte
    sequence s_flash_store;
        flash_store && !(secure_q && page0);
    endsequence
    sequence s_flash_landed;
        flash_wr.wr && flash_wr.addr == $past(cpu_req.xd_addr)
        && flash_wr.data == $past(cpu_req.wdata);
    endsequence
    a_flash_data: assert property (@(posedge clk) disable iff (sys_rst)
        s_flash_store |=> s_flash_landed)
        else $error("flash write lost its address or byte");

    // no store with pwe set, no program pulse
    a_no_flash_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !flash_store |=> !flash_wr.wr)
        else $error("spurious flash write");

    // pwe clear: stores below register space go to data RAM
    a_store_route: assert property (@(posedge clk) disable iff (sys_rst)
        (cpu_req.xd_wr && !pwe_q && cpu_req.xd_addr < FSC_XSFR_BASE)
        |=> xram_wr && !flash_wr.wr)
        else $error("store not routed to RAM");

    // no external-data store, no RAM write pulse
    a_xram_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !cpu_req.xd_wr |=> !xram_wr)
        else $error("spurious RAM write");

    // any setup value but the code disarms fuse control
    a_arm_key: assert property (@(posedge clk) disable iff (sys_rst)
        (key_wr && cpu_req.wdata != FSC_SETUP_CODE) |=> !armed_q)
        else $error("fuse control armed by a reserved value");

    // unarmed, the burn pulse register cannot start a burn
    a_burn_need_arm: assert property (@(posedge clk) disable iff (sys_rst)
        (pulse_wr && !armed_q) |=> !burn_q)
        else $error("burn started without setup code");

    // burn code with everything armed, then the burn output two cycles on
    sequence s_burn_start;
        pulse_wr && cpu_req.wdata == FSC_BURN_CODE && armed_q && perm_q && ^sel_q;
    endsequence
    a_burn_start: assert property (@(posedge clk) disable iff (sys_rst)
        s_burn_start |=> ##1 burn_active)
        else $error("burn did not start");

    // any other value ends the burn two cycles on
    a_burn_stop: assert property (@(posedge clk) disable iff (sys_rst)
        (pulse_wr && cpu_req.wdata != FSC_BURN_CODE) |=> ##1 !burn_active)
        else $error("burn did not stop");

    // permanent-programming output follows bit 7 of the security register
    a_perm_follow: assert property (@(posedge clk) disable iff (sys_rst)
        sec_wr |=> ##1 perm_program == $past(cpu_req.wdata[FSC_PERM_BIT], 2))
        else $error("permanent programming does not follow the write");

    // two stages between pin and status bit
    a_pin_sync: assert property (@(posedge clk) disable iff (sys_rst)
        pin_s2_q == $past(sec_request_pin, 2))
        else $error("pin sync depth wrong");

    // a status read returns the synchronised pin level
    a_pin_status: assert property (@(posedge clk) disable iff (sys_rst)
        (cpu_req.xd_rd && cpu_req.xd_addr == FSC_SEC_STATUS_ADDR && !cpu_req.sfr_rd)
        |=> rdata_valid && rdata[FSC_PIN_BIT] == $past(pin_s2_q))
        else $error("pin status not reported");

    // unimplemented direct addresses answer zero with a valid strobe
    a_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (cpu_req.sfr_rd && cpu_req.sfr_addr != FSC_FLASH_CONTROL_ADDR && !cpu_req.xd_rd)
        |=> rdata_valid && rdata == 8'h00)
        else $error("unimplemented address returned data");

    // protected: debug reads are refused one cycle later
    a_read_block: assert property (@(posedge clk) disable iff (sys_rst)
        (secure_q && debug_read_req) |=> ext_read_block)
        else $error("external read not blocked");

    // outside reset the debug-disable output never falls again
    a_debug_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        debug_disable |=> debug_disable)
        else $error("debug interface came back");
endmodule

// *** testbench.sv ***
// self-checking bench for the flash security control block
// assumes fsc_pkg and fsc_top are compiled first; the bench drives every port itself
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import fsc_pkg::*;
    localparam int PB = 9;  // page size in address bits, small page keeps page zero easy to hit
    logic          clk = 1'b0;
    logic          sys_rst = 1'b1;
    fsc_cpu_req_t  req;
    logic          irq_en, dbg_rd, dbg_wr, pin, f0, f1;
    logic [7:0]    rdata;
    logic          rvalid, xram_wr, mee, cprot, xblock, burn, perm, dbgoff;
    logic [1:0]    bsel;
    fsc_flash_wr_t fw;
    logic          pwe_m, sec_m;  // reference copies of the write enable and protect flags
    int            n_fail = 0;
    int            n_compared = 0;

    always #12.5 clk = ~clk;

    fsc_top #(.PAGE_BITS(PB)) dut (.clk(clk), .sys_rst(sys_rst), .cpu_req(req),
        .irq_enabled(irq_en), .debug_read_req(dbg_rd), .debug_page0_wr(dbg_wr),
        .sec_request_pin(pin), .fuse0_blown(f0), .fuse1_blown(f1), .rdata(rdata),
        .rdata_valid(rvalid), .flash_wr(fw), .xram_wr(xram_wr), .mass_erase_armed(mee),
        .code_protect(cprot), .ext_read_block(xblock), .burn_active(burn),
        .burn_select(bsel), .perm_program(perm), .debug_disable(dbgoff));

    task automatic give_verdict;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s is %b, expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s is %h, expected %h", $time, what, got, exp);
        end
    endtask

    // one strobe cycle; qualifiers held until the taking edge, answer sampled after it
    task automatic access(input bit sfr, input bit wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        req.sfr_wr = sfr & wr;
        req.sfr_rd = sfr & !wr;
        req.xd_wr = !sfr & wr;
        req.xd_rd = !sfr & !wr;
        req.sfr_addr = a[7:0];
        req.xd_addr = a;
        req.wdata = d;
        @(posedge clk);
        #2;
        req = '0;
    endtask

    task automatic rd(input bit sfr, input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
        access(sfr, 0, a, 8'h00);
        chk_bit(rvalid, 1'b1, "read valid");
        chk_val(24'(rdata & m), 24'(e & m), "read data");
    endtask

    task automatic write_ctl(input logic [7:0] d);
        if (!irq_en) pwe_m = d[0];
        sec_m = sec_m | d[6];
        access(1, 1, 16'(FSC_FLASH_CONTROL_ADDR), d);
        // flag outputs are registered once more behind the flags themselves
        @(posedge clk);
        #2;
        chk_bit(mee, d[1], "mass erase armed");
        chk_bit(cprot, sec_m, "code protect");
    endtask

    task automatic store(input logic [15:0] a, input logic [7:0] d);
        logic fl;
        fl = pwe_m && a < FSC_XSFR_BASE && !(sec_m && (a >> PB) == 16'h0000);
        access(0, 1, a, d);
        chk_bit(fw.wr, fl, "flash write");
        if (fl) chk_val({fw.addr, fw.data}, {a, d}, "flash address and byte");
        chk_bit(xram_wr, !pwe_m && a < FSC_XSFR_BASE, "ram write");
        // any store taken as a flash write uses up the enable, even one page zero refuses
        if (pwe_m && a < FSC_XSFR_BASE) pwe_m = 1'b0;
    endtask

    // burn flag must reach its level within a few cycles; a hang ends the run
    task automatic wait_burn(input logic e);
        int i;
        for (i = 0; i < 4 && burn !== e; i++) begin
            @(posedge clk);
            #2;
        end
        chk_bit(burn, e, "burn active");
        if (burn !== e) give_verdict();
    endtask

    task automatic do_reset(input logic fuse1);
        f1 = fuse1;
        pin = fuse1;
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        #2 sys_rst = 1'b0;
        pwe_m = 1'b0;
        sec_m = 1'b0;
        repeat (2) @(posedge clk);
        #2;
        chk_bit(dbgoff, fuse1, "debug disable");
        chk_bit(cprot, 1'b0, "code protect after reset");
        chk_bit(mee, 1'b0, "mass erase after reset");
        rd(1, 16'(FSC_FLASH_CONTROL_ADDR), 8'h00, 8'h41);
    endtask

    initial begin
        void'($urandom(18));
        req = '0;
        {irq_en, dbg_rd, dbg_wr, pin, f0, f1, pwe_m, sec_m} = '0;
        do_reset(1'b0);
        // byte writes: each needs a fresh enable, the second store falls back to ram
        repeat (4) begin
            write_ctl(8'h01);
            store(16'($urandom_range(16'hfbff, 16'h0000)), 8'($urandom));
            store(16'($urandom_range(16'hfbff, 16'h0000)), 8'($urandom));
        end
        irq_en = 1'b1;
        write_ctl(8'h01);
        store(16'h1234, 8'h5a);
        irq_en = 1'b0;
        write_ctl(8'h02);
        write_ctl(8'h00);
        // unused locations are only ever read, never written
        rd(1, 16'h0081, 8'h00, 8'hff);
        rd(0, 16'hfc00, 8'h00, 8'hff);
        // protect flag: set only, blocks external reads and page-zero writes
        write_ctl(8'h41);
        write_ctl(8'h00);
        rd(1, 16'(FSC_FLASH_CONTROL_ADDR), {1'b0, sec_m, 5'b0, pwe_m}, 8'h41);
        for (int k = 0; k < 4; k++) begin
            {dbg_rd, dbg_wr} = 2'(k);
            repeat (2) @(posedge clk);
            #2;
            chk_bit(xblock, sec_m & (dbg_rd | dbg_wr), "external read block");
        end
        write_ctl(8'h01);
        store(16'h0040, 8'h3c);
        write_ctl(8'h01);
        store(16'h0200, 8'hc3);
        // request pin and code-protect fuse level seen through the status register
        repeat (4) begin
            {pin, f0} = 2'($urandom);
            repeat (2) @(posedge clk);
            rd(0, FSC_SEC_STATUS_ADDR, {2'b0, pin, 3'b0, 1'b0, f0}, 8'h21);
        end
        // fuse burn in both modes, started by the burn code and stopped by any other value
        for (int m = 1; m <= 2; m++) begin
            access(0, 1, FSC_SETUP_KEY_ADDR, FSC_SETUP_CODE);
            access(0, 1, FSC_SEC_STATUS_ADDR, 8'(8'h80 | m));
            #25 chk_val(24'(bsel), 24'(m), "burn select");
            chk_bit(perm, 1'b1, "permanent programming");
            access(0, 1, FSC_BURN_PULSE_ADDR, FSC_BURN_CODE);
            wait_burn(1'b1);
            // firmware holds the burn about 500 us, 20000 cycles at 40 MHz
            repeat (20000) @(posedge clk);
            #2;
            chk_bit(burn, 1'b1, "burn held");
            // mode 0 stops with an arbitrary other value, mode 1 with zero as firmware does
            access(0, 1, FSC_BURN_PULSE_ADDR,
                   m == 2 ? 8'h00 : 8'($urandom_range(8'ha5, 8'h00)));
            wait_burn(1'b0);
        end
        access(0, 1, FSC_SEC_STATUS_ADDR, 8'h00);
        @(posedge clk);
        #2;
        chk_bit(perm, 1'b0, "normal operation");
        // after a reset the setup key is gone, so the burn code alone must do nothing
        do_reset(1'b1);
        rd(0, FSC_SEC_STATUS_ADDR, {2'b0, pin, 3'b0, f1, f0}, 8'h23);
        // the fuse was taken during reset; a later change must not reach the output
        f1 = 1'b0;
        access(0, 1, FSC_SEC_STATUS_ADDR, 8'h81);
        access(0, 1, FSC_BURN_PULSE_ADDR, FSC_BURN_CODE);
        repeat (3) @(posedge clk);
        #2;
        chk_bit(burn, 1'b0, "burn without setup");
        chk_bit(dbgoff, 1'b1, "debug disable held");
        give_verdict();
    end
endmodule
